// ===== design/gpio_pkg.sv
package gpio_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_A      = 8'h05;
    localparam logic [7:0] ADDR_PORT_B      = 8'h06;
    localparam logic [7:0] ADDR_INT_CTRL    = 8'h0b;
    localparam logic [7:0] ADDR_CMP_CTRL    = 8'h1f;
    localparam logic [7:0] ADDR_BIT_OP      = 8'h40;
    localparam logic [7:0] ADDR_OPTION      = 8'h81;
    localparam logic [7:0] ADDR_DIR_A       = 8'h85;
    localparam logic [7:0] ADDR_DIR_B       = 8'h86;
    localparam logic [7:0] ADDR_VREF_CTRL   = 8'h9f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OPTION       = 8'hff;
    localparam logic [4:0] RST_DIR_A        = 5'h1f;
    localparam logic [7:0] RST_DIR_B        = 8'hff;
    localparam logic [5:0] RST_CMP_CTRL     = 6'h00;
    localparam logic [6:0] RST_VREF_CTRL    = 7'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPT_PULLUP_EN_N  = 7;
    localparam int INT_CHANGE_FLAG  = 0;
    localparam int INT_CHANGE_EN    = 3;
    localparam int INT_EXT_EN       = 4;
    localparam int BITOP_PORT_SEL   = 7;
    localparam int BITOP_VALUE      = 6;
    localparam int VREF_OUT_EN      = 6;
    localparam int CMP_INV_SEL      = 3;

    // Comparator modes (field CM in comparator_control)
    localparam logic [2:0] CMP_MODE_OFF     = 3'h7;
    localparam logic [2:0] CMP_MODE_OUTPUTS = 3'h6;

    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] pa_s1;
        logic [4:0] pa_s2;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic       prog_s1;
        logic       prog_s2;
        logic [4:0] pa_lat;
        logic [7:0] pb_lat;
        logic [4:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] option;
        logic [5:0] cmp_ctrl;
        logic [6:0] vref_ctrl;
        logic [3:0] change_ref;
        logic       change_flag;
        logic       change_en;
        logic       ext_en;
        logic [7:0] rdata;
    } gpio_state_t;

endpackage

// ===== design/gpio_dual_port.sv
module gpio_dual_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // Port A pins
    input  wire logic [4:0] PA_IN,
    output logic      [4:0] PA_OUT,
    output logic      [4:0] PA_OE_N,
    // Port B pins
    input  wire logic [7:0] PB_IN,
    output logic      [7:0] PB_OUT,
    output logic      [7:0] PB_OE_N,
    output logic      [7:0] PB_PULLUP_EN,
    output logic      [7:0] PB_SCHMITT_EN,
    // Comparator and reference
    input  wire logic       CMP1_RESULT,
    input  wire logic       CMP2_RESULT,
    output logic      [2:0] CMP_MODE,
    output logic            CMP_INPUT_SWAP,
    output logic      [6:0] VREF_CTRL,
    output logic            VREF_PIN_EN,
    // Timer, interrupt and programming
    output logic      [6:0] TIMER_CFG,
    output logic            TIMER_EXT_CLK,
    output logic            EXT_IRQ_IN,
    output logic            CHANGE_IRQ,
    output logic            WAKE_REQ,
    input  wire logic       PROG_MODE,
    output logic            PROG_CLK,
    output logic            PROG_DATA
);

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // 0x05  Port A pins on read, output latch on write
    // 0x06  Port B pins on read, output latch on write
    // 0x0b  Interrupt control: flag b0, change enable b3,
    //       external interrupt enable b4
    // 0x1f  Comparator control: results b7:6 read only,
    //       swap b3, mode b2:0
    // 0x40  Bit modify, write only: port b7, value b6,
    //       bit index b2:0
    // 0x81  Option: pull-up enable low b7, timer setup b6:0
    // 0x85  Port A direction, five bits, 1 floats the pin
    // 0x86  Port B direction, 1 floats the pin
    // 0x9f  Reference control, bit 4 absent and reads zero
    //
    // Unmapped reads return zero and unmapped writes vanish,
    // so software probing the map never disturbs the pins.

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // A write lands at the edge that samples the strobe; read
    // data stand for the following cycle only, zero otherwise.
    // Pin levels take two edges to become readable, so a write
    // to a port followed at once by a read of it shows the old
    // level. Software should leave two spare cycles between them.
    // Strobes may follow each other with no gap; the block never
    // stalls the bus.
    // Internal reset ends two edges after the reset pin rises.

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_ff;
    logic rst_n_ff;

    // Assertion is immediate; release is held back two edges so
    // no flop leaves reset on a metastable level.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Replace one bit of a byte; shared by both ports' bit modify
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] idx,
                                           input logic       b);
        logic [7:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction

    // Exact address match
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state but the reset synchroniser lives in one struct, registered as a whole
    gpio_state_t state_ff;
    gpio_state_t nxt_state;

    logic [4:0] pa_read;
    logic [7:0] pb_pins;
    logic [7:0] pb_mod;
    logic [7:0] pa_mod;
    logic       analog_in;
    logic       cmp_out_mode;
    logic       pb_access;
    logic       bitop_wr;
    logic [3:0] change_live;
    logic       mismatch;
    logic       int_wr;

    always_comb begin
        nxt_state = state_ff;

        // Pins pass two flops before anything reads them
        // The first flop is read only by the second
        nxt_state.pa_s1   = PA_IN;
        nxt_state.pa_s2   = state_ff.pa_s1;
        nxt_state.pb_s1   = PB_IN;
        nxt_state.pb_s2   = state_ff.pb_s1;
        nxt_state.prog_s1 = PROG_MODE;
        nxt_state.prog_s2 = state_ff.prog_s1;

        // Any mode but all-digital turns bits 3..0 analog
        analog_in    = state_ff.cmp_ctrl[2:0] != CMP_MODE_OFF;
        cmp_out_mode = state_ff.cmp_ctrl[2:0] == CMP_MODE_OUTPUTS;
        pb_pins      = state_ff.pb_s2;

        // Analog-selected pins read as zero; bit 4 stays digital
        pa_read = analog_in ? {state_ff.pa_s2[4], 4'h0}
                            : state_ff.pa_s2;

        // Bit modify: pins read, one bit changed, all written back
        // Input pins load their sensed level into their own latch
        // bit; a later switch to output drives that level, not the
        // value once written.
        // Port A takes the read value, analog zeros included.
        bitop_wr = WR && hit(ADDR, ADDR_BIT_OP);
        pa_mod   = put_bit({3'h0, pa_read}, WDATA[2:0],
                           WDATA[BITOP_VALUE]);
        pb_mod   = put_bit(pb_pins, WDATA[2:0],
                           WDATA[BITOP_VALUE]);

        if (bitop_wr && !WDATA[BITOP_PORT_SEL]) begin
            nxt_state.pa_lat = pa_mod[4:0];
        end
        if (bitop_wr && WDATA[BITOP_PORT_SEL]) begin
            nxt_state.pb_lat = pb_mod;
        end

        // Plain writes carry the value already modified by software
        if (WR) begin
            if (hit(ADDR, ADDR_PORT_A)) begin
                nxt_state.pa_lat = WDATA[4:0];
            end
            if (hit(ADDR, ADDR_PORT_B)) begin
                nxt_state.pb_lat = WDATA;
            end
            if (hit(ADDR, ADDR_DIR_A)) begin
                nxt_state.dir_a = WDATA[4:0];
            end
            if (hit(ADDR, ADDR_DIR_B)) begin
                nxt_state.dir_b = WDATA;
            end
            if (hit(ADDR, ADDR_OPTION)) begin
                nxt_state.option = WDATA;
            end
            if (hit(ADDR, ADDR_CMP_CTRL)) begin
                nxt_state.cmp_ctrl = WDATA[5:0];
            end
            if (hit(ADDR, ADDR_VREF_CTRL)) begin
                nxt_state.vref_ctrl = {WDATA[7:5], WDATA[3:0]};
            end
            if (hit(ADDR, ADDR_INT_CTRL)) begin
                nxt_state.change_en = WDATA[INT_CHANGE_EN];
                nxt_state.ext_en    = WDATA[INT_EXT_EN];
            end
        end

        // --------------------------------------------------------
        // Change detect
        // --------------------------------------------------------
        // Any port B access re-latches the reference and ends the
        // mismatch; a change in that same cycle is absorbed.
        // Only pins 7..4 set as inputs take part; an output pin
        // follows its own latch and would otherwise flag itself.
        // The flag is sticky: while a mismatch stands it is set
        // again on every edge, so a clear only holds once the
        // reference has been refreshed by a port B access.
        // Software that polls port B hides changes; poll the
        // flag instead.
        pb_access = (RD || WR) && hit(ADDR, ADDR_PORT_B)
                 || bitop_wr && WDATA[BITOP_PORT_SEL];
        if (pb_access) begin
            nxt_state.change_ref = pb_pins[7:4];
        end

        change_live = (pb_pins[7:4] ^ state_ff.change_ref)
                    & state_ff.dir_b[7:4];
        mismatch    = |change_live && !pb_access;

        int_wr = WR && hit(ADDR, ADDR_INT_CTRL);
        if (mismatch) begin
            nxt_state.change_flag = 1'b1;
        end else if (int_wr) begin
            nxt_state.change_flag = WDATA[INT_CHANGE_FLAG];
        end

        // --------------------------------------------------------
        // Read data, one cycle after the strobe
        // --------------------------------------------------------
        // Registered so the answer stands alone in the cycle after
        // the strobe; any other cycle reads zero, which keeps an
        // OR-combined read bus clean.
        nxt_state.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                ADDR_PORT_A:    nxt_state.rdata = {3'h0, pa_read};
                ADDR_PORT_B:    nxt_state.rdata = pb_pins;
                ADDR_DIR_A:     nxt_state.rdata = {3'h0, state_ff.dir_a};
                ADDR_DIR_B:     nxt_state.rdata = state_ff.dir_b;
                ADDR_OPTION:    nxt_state.rdata = state_ff.option;
                ADDR_CMP_CTRL:  nxt_state.rdata = {CMP2_RESULT, CMP1_RESULT,
                                                   state_ff.cmp_ctrl};
                ADDR_VREF_CTRL: nxt_state.rdata = {state_ff.vref_ctrl[6:4],
                                                   1'b0,
                                                   state_ff.vref_ctrl[3:0]};
                ADDR_INT_CTRL:  nxt_state.rdata = {3'h0,
                                                   state_ff.ext_en,
                                                   state_ff.change_en,
                                                   2'h0,
                                                   state_ff.change_flag};
                default:        nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            // Pin synchronisers clear too; a high input pin then looks
            // like a change two edges after reset, so software should
            // read port B before enabling the change interrupt.
            state_ff           <= '0;
            state_ff.dir_a     <= RST_DIR_A;
            state_ff.dir_b     <= RST_DIR_B;
            state_ff.option    <= RST_OPTION;
            state_ff.cmp_ctrl  <= RST_CMP_CTRL;
            state_ff.vref_ctrl <= RST_VREF_CTRL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Port B pull-ups are gated by direction so an output never
    // fights its own weak pull-up, and reset leaves them off.
    // Port A bit 4 has no high driver: a 1 releases the line and
    // an outside pull-up must raise it.
    logic a3_val;
    logic a4_val;

    // Comparator outputs need the direction bits cleared to reach pins
    assign a3_val = cmp_out_mode ? CMP1_RESULT
                                 : state_ff.pa_lat[3];
    assign a4_val = cmp_out_mode ? CMP2_RESULT
                                 : state_ff.pa_lat[4];

    assign PA_OUT  = {1'b0, a3_val, state_ff.pa_lat[2:0]};
    // Bit 4 only ever pulls low
    assign PA_OE_N = {state_ff.dir_a[4] | a4_val,
                      state_ff.dir_a[3:0]};

    assign PB_OUT  = state_ff.pb_lat;
    assign PB_OE_N = state_ff.dir_b;
    assign PB_PULLUP_EN = {8{~state_ff.option[OPT_PULLUP_EN_N]}}
                        & state_ff.dir_b;
    assign PB_SCHMITT_EN = {{2{state_ff.prog_s2}}, 5'h00,
                            state_ff.ext_en};

    // ------------------------------------------------------------
    // Side functions
    // ------------------------------------------------------------
    // Timer clock, interrupt and programming pins go out through
    // the same two flops as the port reads, so every consumer of
    // a pin sees one consistent, settled level.
    assign CMP_MODE       = state_ff.cmp_ctrl[2:0];
    assign CMP_INPUT_SWAP = state_ff.cmp_ctrl[CMP_INV_SEL];
    assign VREF_CTRL      = state_ff.vref_ctrl;
    // Stored copy lacks register bit 4, so bits above it sit one lower
    assign VREF_PIN_EN    = state_ff.vref_ctrl[VREF_OUT_EN - 1];
    assign TIMER_CFG      = state_ff.option[6:0];
    assign TIMER_EXT_CLK  = state_ff.pa_s2[4];
    assign EXT_IRQ_IN     = state_ff.pb_s2[0];
    assign PROG_CLK       = state_ff.pb_s2[6];
    assign PROG_DATA      = state_ff.pb_s2[7];
    // Wake request needs both the flag and its enable
    assign CHANGE_IRQ     = state_ff.change_flag;
    assign WAKE_REQ       = state_ff.change_flag
                          & state_ff.change_en;
    assign RDATA          = state_ff.rdata;

endmodule // gpio_dual_port

// ===== dv/gpio_pins.sv
module gpio_pins
    import gpio_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Device side of the pins
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [7:0] pb_pu,
    input  wire logic [4:0] pa_out,
    input  wire logic [4:0] pa_oe_n,
    // Outside drivers
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_b_en,
    input  wire logic [4:0] ext_a,
    // Resolved levels
    output logic      [7:0] pb_in,
    output logic      [4:0] pa_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pb_q;
    always @(posedge clk) pb_q <= pb_in;
    // ------
    // Wire resolution: an undriven line without pull-up
    // wanders, so nothing may lean on its last value
    // ------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pb_oe_n[i])
                pb_in[i] = pb_out[i];
            else if (ext_b_en[i])
                pb_in[i] = ext_b[i];
            else if (pb_pu[i])
                pb_in[i] = 1'b1;
            else
                pb_in[i] = ~pb_q[i];
        end
        for (int i = 0; i < 5; i++)
            pa_in[i] = pa_oe_n[i] ? ext_a[i] : pa_out[i];
    end
endmodule // gpio_pins

// ===== dv/gpio_dual_port_chk.sv
module gpio_dual_port_chk
    import gpio_pkg::*;
(
    // Clock, reset and register port
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // Pins and flags
    input wire logic [4:0] PA_OUT,
    input wire logic [4:0] PA_OE_N,
    input wire logic [2:0] CMP_MODE,
    input wire logic [7:0] PB_IN,
    input wire logic [7:0] PB_OUT,
    input wire logic [7:0] PB_OE_N,
    input wire logic [7:0] PB_PULLUP_EN,
    input wire logic       CHANGE_IRQ,
    input wire logic       WAKE_REQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic       w7n;
    logic [3:0] hi;
    assign w7n = ~WDATA[7];
    assign hi  = PB_IN[7:4];
    // Cycles since reset release, so pin syncs have settled
    logic [2:0] up_cnt;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            up_cnt <= 3'h0;
        else if (up_cnt != 3'h7)
            up_cnt <= up_cnt + 3'h1;
    end
    // ------
    // Properties
    // ------
    property p_pu_out;
        (PB_PULLUP_EN & ~PB_OE_N) == 8'h00;
    endproperty
    property p_od;
        PA_OUT[4] == 1'b0;
    endproperty
    property p_wr_b;
        WR && ADDR == ADDR_PORT_B |=> PB_OUT == $past(WDATA);
    endproperty
    property p_dir_b;
        WR && ADDR == ADDR_DIR_B |=> PB_OE_N == $past(WDATA);
    endproperty
    property p_opt;
        WR && ADDR == ADDR_OPTION
        |=> PB_PULLUP_EN == ({8{$past(w7n)}} & PB_OE_N);
    endproperty
    property p_rd_b;
        RD && ADDR == ADDR_PORT_B && PB_IN == $past(PB_IN)
        && PB_IN == $past(PB_IN, 2) && PB_IN == $past(PB_IN, 3)
        |=> RDATA == $past(PB_IN);
    endproperty
    property p_wake;
        WAKE_REQ |-> CHANGE_IRQ;
    endproperty
    property p_excl;
        up_cnt == 3'h7 && !CHANGE_IRQ && $stable(PB_OE_N)
        && !(WR && ADDR == ADDR_INT_CTRL)
        && (($past(hi, 2) ^ $past(hi, 3)) & PB_OE_N[7:4]) == 4'h0
        |=> !CHANGE_IRQ;
    endproperty
    property p_od_rel;
        WR && ADDR == ADDR_PORT_A && WDATA[4]
        && CMP_MODE != CMP_MODE_OUTPUTS |=> PA_OE_N[4];
    endproperty
    property p_set;
        ((hi ^ $past(hi)) & PB_OE_N[7:4]) != 4'h0
        ##1 (!WR && !RD && $stable(PB_IN) && $stable(PB_OE_N)) [*4]
        |-> CHANGE_IRQ;
    endproperty
    a_pu_out: assert property (p_pu_out) else $error("pull-up on output");
    a_od: assert property (p_od) else $error("bit4 drives high");
    a_wr_b: assert property (p_wr_b) else $error("latch b wrong");
    a_dir_b: assert property (p_dir_b) else $error("dir b wrong");
    a_opt: assert property (p_opt) else $error("pull-up cfg");
    a_rd_b: assert property (p_rd_b) else $error("pin read b");
    a_wake: assert property (p_wake) else $error("wake no flag");
    a_excl: assert property (p_excl) else $error("output set flag");
    a_set: assert property (p_set) else $error("change missed");
    a_od_rel: assert property (p_od_rel) else $error("bit4 held");
    c_irq: cover property ($rose(CHANGE_IRQ));
    c_wake: cover property (WAKE_REQ);
    c_pu: cover property (PB_PULLUP_EN != 8'h00);
endmodule // gpio_dual_port_chk

bind gpio_dual_port gpio_dual_port_chk u_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PA_OUT(PA_OUT), .PB_IN(PB_IN),
    .PA_OE_N(PA_OE_N), .CMP_MODE(CMP_MODE),
    .PB_OUT(PB_OUT), .PB_OE_N(PB_OE_N), .PB_PULLUP_EN(PB_PULLUP_EN),
    .CHANGE_IRQ(CHANGE_IRQ), .WAKE_REQ(WAKE_REQ));

// ===== dv/testbench.sv
module testbench
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, rst_n, wr_s, rd_s, cmp1, cmp2, prog, irq, wake;
    logic [7:0] addr, wdata, rdata, ext_b, pb_in, pb_out, pb_oe, pb_pu, sch;
    logic [4:0] ext_a, pa_in, pa_out, pa_oe;
    logic [6:0] vref_c, tcfg;
    logic [2:0] cmode;
    logic       swap, vpin, tclk, eirq, pclk, pdat;
    int         fail_count, compares;
    logic [7:0] ra [6] = '{ADDR_OPTION, ADDR_DIR_A, ADDR_DIR_B,
                           ADDR_CMP_CTRL, ADDR_VREF_CTRL, 8'h33};
    logic [7:0] rv [6] = '{RST_OPTION, {3'h0, RST_DIR_A}, RST_DIR_B,
                           {2'h0, RST_CMP_CTRL}, {1'b0, RST_VREF_CTRL}, 8'h00};

    gpio_dual_port u_gpio_dual_port (
        .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .PA_IN(pa_in),
        .PA_OUT(pa_out), .PA_OE_N(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out),
        .PB_OE_N(pb_oe), .PB_PULLUP_EN(pb_pu), .PB_SCHMITT_EN(sch),
        .CMP1_RESULT(cmp1), .CMP2_RESULT(cmp2), .CMP_MODE(cmode),
        .CMP_INPUT_SWAP(swap), .VREF_CTRL(vref_c), .VREF_PIN_EN(vpin),
        .TIMER_CFG(tcfg), .TIMER_EXT_CLK(tclk), .EXT_IRQ_IN(eirq),
        .CHANGE_IRQ(irq), .WAKE_REQ(wake),
        .PROG_MODE(prog), .PROG_CLK(pclk), .PROG_DATA(pdat));
    gpio_pins u_gpio_pins (
        .clk(clk), .pb_out(pb_out), .pb_oe_n(pb_oe), .pb_pu(pb_pu),
        .pa_out(pa_out), .pa_oe_n(pa_oe), .ext_b(ext_b),
        .ext_b_en(8'hff), .ext_a(ext_a), .pb_in(pb_in), .pa_in(pa_in));

    task automatic chk(input logic [7:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t %s: %h /= %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, e, input string m);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e, m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (irq !== 1'b1) begin
            fail_count++;
            $display("[FAIL] %0t change flag never rose", $time);
            test_done();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------
    // Main sequence
    // ------
    initial begin
        {rst_n, wr_s, rd_s, cmp1, cmp2, prog} = 6'h00;
        {addr, wdata} = 16'h0000;
        ext_b = 8'ha5;
        ext_a = 5'h1f;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        idle(3);
        for (int i = 0; i < 6; i++)
            rdc(ra[i], rv[i], "reset value");
        chk(pb_pu, 8'h00, "pull-ups at reset");
        wr(ADDR_VREF_CTRL, 8'hff);
        rdc(ADDR_VREF_CTRL, 8'hef, "vref bit4");
        chk({vpin, vref_c}, 8'hff, "vref outputs");
        $display("test regs done");
        wr(ADDR_DIR_B, 8'hf0);
        chk(pb_oe, 8'hf0, "dir b");
        wr(ADDR_PORT_B, 8'h3c);
        chk(pb_out, 8'h3c, "latch b");
        idle(3);
        rdc(ADDR_PORT_B, 8'hac, "pins b");
        wr(ADDR_BIT_OP, 8'h82);
        chk(pb_out, 8'ha8, "bit op");
        wr(ADDR_OPTION, 8'h7f);
        chk(pb_pu, 8'hf0, "pull-up on");
        chk({1'b0, tcfg}, 8'h7f, "timer cfg");
        wr(ADDR_OPTION, 8'hff);
        chk(pb_pu, 8'h00, "pull-up off");
        $display("test port b done");
        rdc(ADDR_PORT_B, 8'ha8, "pins b");
        wr(ADDR_INT_CTRL, 8'h18);
        chk({7'h0, irq}, 8'h00, "flag cleared");
        chk(sch, 8'h01, "schmitt ext irq");
        @(posedge clk);
        ext_b <= 8'h85;
        wait_irq();
        idle(1);
        chk({7'h0, wake}, 8'h01, "wake");
        wr(ADDR_INT_CTRL, 8'h18);
        chk({7'h0, irq}, 8'h01, "clear refused");
        rdc(ADDR_PORT_B, 8'h88, "pins b");
        wr(ADDR_INT_CTRL, 8'h18);
        chk({7'h0, irq}, 8'h00, "clear holds");
        wr(ADDR_DIR_B, 8'hef);
        idle(3);
        rdc(ADDR_PORT_B, 8'h85, "pins b");
        chk({5'h0, pdat, pclk, eirq}, 8'h05, "pin taps");
        wr(ADDR_PORT_B, 8'h10);
        idle(6);
        chk({7'h0, irq}, 8'h00, "output excluded");
        @(posedge clk);
        prog <= 1'b1;
        idle(4);
        chk(sch, 8'hc1, "schmitt prog");
        $display("test change done");
        rdc(ADDR_PORT_A, 8'h10, "analog zeros");
        wr(ADDR_CMP_CTRL, 8'hff);
        @(posedge clk);
        cmp1 <= 1'b1;
        idle(1);
        rdc(ADDR_CMP_CTRL, 8'h7f, "cmp status");
        chk({4'h0, swap, cmode}, 8'h0f, "cmp mode");
        wr(ADDR_CMP_CTRL, 8'h07);
        wr(ADDR_DIR_A, 8'h00);
        wr(ADDR_PORT_A, 8'h15);
        chk({3'h0, pa_oe}, 8'h10, "open drain");
        chk({3'h0, pa_out}, 8'h05, "drive a");
        idle(3);
        rdc(ADDR_PORT_A, 8'h15, "pins a");
        chk({7'h0, tclk}, 8'h01, "timer clock pin");
        $display("test port a done");
        test_done();
    end
endmodule // testbench
